// ===== pkg/sipo_latch_params.svh
// Functional notes
// - Eight-stage shift register loads serially and shows all stages to storage.
// - Eight-bit storage register captures shift stages on storage clock.
// - Shift and storage registers each have their own clock input.
// - Each register has a low-active clear forcing zeros, overriding its clock.
// - Both clocks act only on their rising edges.
// - With tied clocks, storage takes pre-shift contents, lagging one pulse.
// - Serial output carries the last stage for cascading.
`ifndef SIPO_LATCH_PARAMS_SVH
`define SIPO_LATCH_PARAMS_SVH
`define STAGES        8
`define LAST_STAGE    7
`define ZERO_BYTE     8'h00
`define FIFO_DEPTH    16
`define FIFO_PTR_W    4
`define FIFO_CNT_W    5
`endif

// ===== pkg/sipo_latch_pkg.sv
package sipo_latch_pkg;
  typedef logic [7:0] byte_t;
endpackage

// ===== design/capture_fifo.sv
`timescale 1ns/1ps
`include "sipo_latch_params.svh"
module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [CW-1:0]    count_r, count_nxt;
  logic [WIDTH-1:0] outData_r, outData_nxt;
  logic             outValid_r, outValid_nxt, inReady_r, inReady_nxt;
  logic             push, pop;

  // ==========================================================
  // Next state
  always_comb begin
    push        = inValid && inReady_r;
    pop         = (count_r != '0) && (!outValid_r || outReady);
    wrPtr_nxt   = push ? PW'(wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt   = pop ? PW'(rdPtr_r + 1'b1) : rdPtr_r;
    count_nxt   = CW'(count_r + CW'(push) - CW'(pop));
    outData_nxt = pop ? mem[rdPtr_r] : outData_r;
    outValid_nxt = pop ? 1'b1 : (outValid_r && !outReady);
    // Registered ready keeps top outputs glitch free
    inReady_nxt = (count_nxt != CW'(DEPTH));
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r    <= '0;
      rdPtr_r    <= '0;
      count_r    <= '0;
      outData_r  <= '0;
      outValid_r <= 1'b0;
      inReady_r  <= 1'b1;
    end else begin
      wrPtr_r    <= wrPtr_nxt;
      rdPtr_r    <= rdPtr_nxt;
      count_r    <= count_nxt;
      outData_r  <= outData_nxt;
      outValid_r <= outValid_nxt;
      inReady_r  <= inReady_nxt;
    end
  end

  // Storage array has no reset; reads only after a write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  assign inReady  = inReady_r;
  assign outData  = outData_r;
  assign outValid = outValid_r;
endmodule

// ===== design/sipo_latch.sv
`timescale 1ns/1ps
`include "sipo_latch_params.svh"
module sipo_latch (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // Serial side
  input  wire logic                 serialIn,
  input  wire logic                 shift_clock,
  input  wire logic                 shift_clear_n,
  output logic                      serialOut,
  // Storage side
  input  wire logic                 storage_clock,
  input  wire logic                 storage_clear_n,
  output sipo_latch_pkg::byte_t     parallelOut,
  // Capture stream
  output logic                      captureRoom,
  output sipo_latch_pkg::byte_t     capData,
  output logic                      capValid,
  input  wire logic                 capReady
);
  import sipo_latch_pkg::*;

  byte_t shiftReg_r, shiftReg_nxt;
  byte_t storeReg_r, storeReg_nxt;
  logic  shiftPrev_r, shiftPrev_nxt;
  logic  storePrev_r, storePrev_nxt;
  logic  serialOut_r, serialOut_nxt;
  logic  shiftRise, storeRise, pushValid, fifoReady;

  // Rising edge of a level sampled against its previous sample
  function automatic logic rise(input logic now, input logic prev);
    return now && !prev;
  endfunction

  // ==========================================================
  // Edge detection
  // Inputs are synchronous to mclk, so one flop of history suffices
  always_comb begin
    shiftPrev_nxt = shift_clock;
    storePrev_nxt = storage_clock;
    shiftRise = rise(shift_clock, shiftPrev_r);
    storeRise = rise(storage_clock, storePrev_r);
  end

  // ==========================================================
  // Shift register
  always_comb begin
    shiftReg_nxt = shiftReg_r;
    if (!shift_clear_n) begin
      shiftReg_nxt = `ZERO_BYTE;
    end else if (shiftRise) begin
      shiftReg_nxt = {shiftReg_r[`LAST_STAGE-1:0], serialIn};
    end
    serialOut_nxt = shiftReg_nxt[`LAST_STAGE];
  end

  // ==========================================================
  // Storage register
  // Old shift contents are read, giving the one-pulse lag when tied
  always_comb begin
    storeReg_nxt = storeReg_r;
    if (!storage_clear_n) begin
      storeReg_nxt = `ZERO_BYTE;
    end else if (storeRise) begin
      storeReg_nxt = shiftReg_r;
    end
    // A capture while the FIFO is full is not queued
    pushValid = storage_clear_n && storeRise;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg_r  <= `ZERO_BYTE;
      storeReg_r  <= `ZERO_BYTE;
      shiftPrev_r <= 1'b0;
      storePrev_r <= 1'b0;
      serialOut_r <= 1'b0;
    end else begin
      shiftReg_r  <= shiftReg_nxt;
      storeReg_r  <= storeReg_nxt;
      shiftPrev_r <= shiftPrev_nxt;
      storePrev_r <= storePrev_nxt;
      serialOut_r <= serialOut_nxt;
    end
  end

  // ==========================================================
  // Capture FIFO
  capture_fifo #(
    .WIDTH ($bits(byte_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .inData   (shiftReg_r),
    .inValid  (pushValid),
    .inReady  (fifoReady),
    .outData  (capData),
    .outValid (capValid),
    .outReady (capReady)
  );

  assign parallelOut = storeReg_r;
  assign serialOut   = serialOut_r;
  assign captureRoom = fifoReady;
endmodule

// ===== tb/sipo_latch_sva.sv
`timescale 1ns/1ps
module sipo_latch_sva (
  // Block pins
  input wire logic mclk, arst_n, serialIn, shift_clock, shift_clear_n,
  input wire logic serialOut, storage_clock, storage_clear_n, captureRoom,
  input wire logic capValid, capReady,
  input wire sipo_latch_pkg::byte_t parallelOut, capData
);
  import sipo_latch_pkg::*;
  // ==========
  // Shadow stages, rebuilt from the pins only
  byte_t shadow_r;
  logic  shPrev_r, stPrev_r;
  wire   shEdge = shift_clock && !shPrev_r && shift_clear_n;
  wire   stEdge = storage_clock && !stPrev_r && storage_clear_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {shadow_r, shPrev_r, stPrev_r} <= 10'h000;
    end else begin
      shPrev_r <= shift_clock;
      stPrev_r <= storage_clock;
      if (!shift_clear_n) shadow_r <= 8'h00;
      else if (shEdge) shadow_r <= {shadow_r[6:0], serialIn};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  last_stage_a: assert property (
    serialOut == shadow_r[7])
    else $error("serial out differs from last stage");
  store_pre_a: assert property (
    stEdge |=> parallelOut == $past(shadow_r))
    else $error("stored byte is not the pre-shift contents");
  shift_clr_a: assert property (
    !shift_clear_n |=> !serialOut)
    else $error("shift clear ignored");
  store_clr_a: assert property (
    !storage_clear_n |=> parallelOut == 8'h00)
    else $error("storage clear ignored");
  store_hold_a: assert property (
    !stEdge && storage_clear_n |=> $stable(parallelOut))
    else $error("outputs moved without a storage edge");
  held_clk_a: assert property (
    shift_clock && shPrev_r && shift_clear_n |=> $stable(serialOut))
    else $error("held shift clock shifted again");
  cap_hold_a: assert property (
    capValid && !capReady |=> capValid && $stable(capData))
    else $error("captured byte dropped while stalled");
  cap_late_a: assert property (
    stEdge && !capValid && captureRoom |-> ##[2:3] capValid)
    else $error("captured byte not offered in time");
  cover property (stEdge);
  cover property (capValid && !capReady);
  cover property (shift_clock && !shift_clear_n);
endmodule
bind sipo_latch sipo_latch_sva chk_u (.*);

// ===== tb/serial_host.sv
`timescale 1ns/1ps
module serial_host (
  // Clock
  input  wire logic mclk,
  // Pins into the block
  output logic      serialIn,
  output logic      shift_clock,
  output logic      storage_clock
);
  initial {serialIn, shift_clock, storage_clock} = 3'h0;
  // MSB first; tied drives both clocks as one wire
  task automatic sendByte(input logic [7:0] b, input logic tied);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      serialIn <= b[i];
      shift_clock <= 1'h1;
      storage_clock <= tied;
      @(posedge mclk);
      serialIn <= ~b[i]; // Stale bit would hide a late sample
      shift_clock <= 1'h0;
      storage_clock <= 1'h0;
    end
    if (!tied) begin
      @(posedge mclk);
      storage_clock <= 1'h1;
      @(posedge mclk);
      storage_clock <= 1'h0;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sipo_latch_pkg::*;
  logic  mclk, arst_n, serialIn, shift_clock, shift_clear_n, serialOut;
  logic  storage_clock, storage_clear_n, captureRoom, capValid, capReady;
  byte_t parallelOut, capData;
  int    err_count, checks;
  byte_t rows [3][2] = '{'{8'hA5, 8'hA5}, '{8'h80, 8'h80}, '{8'h7F, 8'h7F}};
  sipo_latch dut_u (.*);
  serial_host host_u (.*);
  always #50 mclk = ~mclk;
  task automatic chk(string n, byte_t e, byte_t s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("Checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    {mclk, arst_n, capReady, err_count, checks} = '0;
    {shift_clear_n, storage_clear_n} = 2'h3;
    repeat (5) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk) #1;
    chk("captureRoom", 8'h01, captureRoom);
    // Drain stalled so the rows pile up in the buffer
    for (int r = 0; r < 3; r++) begin
      host_u.sendByte(rows[r][0], 1'h0);
      #1;
      chk("parallelOut", rows[r][1], parallelOut);
      chk("serialOut", rows[r][0][7], serialOut);
    end
    $display("Row test done");
    for (int r = 0; r < 3; r++) begin
      for (int w = 0; w < 9 && capValid !== 1'h1; w++) @(posedge mclk) #1;
      chk("capData", rows[r][0], capData);
      @(posedge mclk) capReady <= 1'h1;
      @(posedge mclk) capReady <= 1'h0;
      #1;
    end
    repeat (3) @(posedge mclk);
    #1;
    chk("capValid", 8'h00, capValid);
    $display("Drain test done");
    host_u.sendByte(8'h3C, 1'h1);
    #1;
    chk("tiedPar", 8'h9E, parallelOut);
    $display("Tied clock test done");
    @(posedge mclk);
    shift_clear_n <= 1'h0;
    storage_clear_n <= 1'h0;
    host_u.sendByte(8'hFF, 1'h0);
    #1;
    chk("clrSer", 8'h00, serialOut);
    chk("clrPar", 8'h00, parallelOut);
    $display("Clear test done");
    summarize();
  end
endmodule
